/* File: src/omp_regs.svh */
// Register offsets, field positions, reset values and timing counts
// Assumes a 200 MHz clock and a word-aligned software register port
`ifndef OMP_REGS_SVH
`define OMP_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OMP_OFF_ADDR   8'h00
`define OMP_OFF_DATA   8'h04
`define OMP_OFF_STAT   8'h08

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define OMP_ST_HALT    0
`define OMP_ST_RUN     1
`define OMP_ST_IDLE    2
`define OMP_ST_AHALT   3
`define OMP_ST_MASK    4
`define OMP_ST_ARMED   5
`define OMP_ST_DONE    6
`define OMP_ST_XFER    7
`define OMP_ST_BUSY    8
`define OMP_ST_SYSRST  9

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define OMP_ADDR_RST   16'h0000
`define OMP_DATA_RST   16'h0000
`define OMP_SEL_RST    12'h001
`define OMP_CLK_NS     5
`define OMP_RST_HOLD_NS 1000
`define OMP_RST_HOLD_CYC \
  ((`OMP_RST_HOLD_NS + `OMP_CLK_NS - 1) / `OMP_CLK_NS)

`endif

/* File: src/omp_pkg.sv */
// Types shared by the panel modules
// Assumes nothing beyond a SystemVerilog compiler
package omp_pkg;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {BM_IDLE, BM_WAIT} omp_bm_st_t;
  typedef enum logic [1:0] {OP_IDLE, OP_BUS, OP_REG} omp_op_st_t;

endpackage

/* File: src/omp_bus_master.sv */
// System bus master for panel accesses, one access at a time
// Assumes the target answers each request with a one-cycle ack
module omp_bus_master #(
  parameter int AW = 16,
  parameter int DW = 16
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          start_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          bus_ack_i,
  input  wire logic [DW-1:0] bus_rdata_i,
  output logic               bus_req_o,
  output logic               bus_we_o,
  output logic [AW-1:0]      bus_addr_o,
  output logic [DW-1:0]      bus_wdata_o,
  output logic               done_o,
  output logic [DW-1:0]      rdata_o
);
  import omp_pkg::*;

  omp_bm_st_t    st_q, st_d;
  logic          req_d, we_d, done_d;
  logic [AW-1:0] addr_d;
  logic [DW-1:0] wdata_d, rdata_d;

  always_comb begin
    st_d    = st_q;
    req_d   = bus_req_o;
    we_d    = bus_we_o;
    addr_d  = bus_addr_o;
    wdata_d = bus_wdata_o;
    rdata_d = rdata_o;
    done_d  = 1'b0;
    case (st_q)
      BM_IDLE: begin
        if (start_i) begin
          req_d   = 1'b1;
          we_d    = we_i;
          addr_d  = addr_i;
          wdata_d = wdata_i;
          st_d    = BM_WAIT;
        end
      end
      BM_WAIT: begin
        if (bus_ack_i) begin
          req_d  = 1'b0;
          done_d = 1'b1;
          if (!bus_we_o) begin
            rdata_d = bus_rdata_i;
          end
          st_d = BM_IDLE;
        end
      end
      default: st_d = BM_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q        <= BM_IDLE;
      bus_req_o   <= 1'b0;
      bus_we_o    <= 1'b0;
      bus_addr_o  <= '0;
      bus_wdata_o <= '0;
      rdata_o     <= '0;
      done_o      <= 1'b0;
    end else begin
      st_q        <= st_d;
      bus_req_o   <= req_d;
      bus_we_o    <= we_d;
      bus_addr_o  <= addr_d;
      bus_wdata_o <= wdata_d;
      rdata_o     <= rdata_d;
      done_o      <= done_d;
    end
  end

endmodule // omp_bus_master

/* File: src/omp_hold_timer.sv */
// Holds an active level for a fixed number of cycles after a start
// Assumes start is a one-cycle pulse
module omp_hold_timer #(
  parameter int unsigned HOLD = 200
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic start_i,
  output logic      active_o
);
  localparam int CW = $clog2(HOLD + 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic          act_d;

  always_comb begin
    cnt_d = cnt_q;
    act_d = active_o;
    if (start_i) begin
      act_d = 1'b1;
      cnt_d = CW'(HOLD - 1);
    end else if (active_o) begin
      if (cnt_q == '0) begin
        act_d = 1'b0;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q    <= '0;
      active_o <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      active_o <= act_d;
    end
  end

endmodule // omp_hold_timer

/* File: src/omp_panel.sv */
// Operator maintenance panel: switches to bus and processor actions
// Assumes switch inputs are one-cycle pulses synchronous to REF_CLK_I
`include "omp_regs.svh"

module omp_panel #(
  parameter int          AW   = 16,
  parameter int          DW   = 16,
  parameter int unsigned HOLD = `OMP_RST_HOLD_CYC
) (
  input  wire logic          REF_CLK_I,
  input  wire logic          RST_N_I,
  input  wire logic          SW_OPER_CALL_I,
  input  wire logic          SW_INT_MASK_I,
  input  wire logic          SW_STEP_I,
  input  wire logic          SW_ADDR_HALT_I,
  input  wire logic          SW_HALT_I,
  input  wire logic          SW_RUN_I,
  input  wire logic          SW_LOAD_I,
  input  wire logic          SW_RESET_I,
  input  wire logic [11:0]   SW_SEL_I,
  input  wire logic          SW_REG_RD_I,
  input  wire logic          SW_REG_WR_I,
  input  wire logic          SW_MEM_RD_I,
  input  wire logic          SW_MEM_WR_I,
  input  wire logic [AW-1:0] SW_ADDR_BIT_I,
  input  wire logic          SW_ADDR_CLR_I,
  input  wire logic [DW-1:0] SW_DATA_BIT_I,
  input  wire logic          SW_DATA_CLR_I,
  input  wire logic          SW_PF_EN_I,
  input  wire logic          SW_LF_EN_I,
  input  wire logic [1:0]    SW_PR_MODE_I,
  input  wire logic          CPU_EXEC_I,
  input  wire logic          CPU_WAIT_I,
  input  wire logic [DW-1:0] CPU_REG_RDATA_I,
  input  wire logic          CPU_REG_ACK_I,
  input  wire logic          BUS_BUSY_I,
  input  wire logic          BUS_MON_VALID_I,
  input  wire logic [AW-1:0] BUS_MON_ADDR_I,
  input  wire logic          BUS_ACK_I,
  input  wire logic [DW-1:0] BUS_RDATA_I,
  input  wire logic [7:0]    REG_ADDR_I,
  input  wire logic [31:0]   REG_WDATA_I,
  input  wire logic          REG_WR_I,
  input  wire logic          REG_RD_I,
  output logic [31:0]        REG_RDATA_O,
  output logic               OPER_INT_O,
  output logic [3:0]         INT_MASK_O,
  output logic               CPU_HALT_O,
  output logic               CPU_STEP_O,
  output logic               CPU_RUN_O,
  output logic [3:0]         CPU_REG_SEL_O,
  output logic               CPU_REG_RD_O,
  output logic               CPU_REG_WR_O,
  output logic [DW-1:0]      CPU_REG_WDATA_O,
  output logic               SYS_RESET_O,
  output logic               AUTOLOAD_O,
  output logic               PF_INT_EN_O,
  output logic               LF_INT_EN_O,
  output logic [1:0]         PR_MODE_O,
  output logic               BUS_REQ_O,
  output logic               BUS_WE_O,
  output logic [AW-1:0]      BUS_ADDR_O,
  output logic [DW-1:0]      BUS_WDATA_O,
  output logic [AW-1:0]      LED_ADDR_O,
  output logic [DW-1:0]      LED_DATA_O,
  output logic [11:0]        LED_SEL_O,
  output logic               LED_ADDR_HALT_O,
  output logic               LED_LOAD_O,
  output logic               LED_DONE_O,
  output logic               LED_BUSY_O,
  output logic               LED_RUN_O,
  output logic               LED_IDLE_O,
  output logic               LED_HALT_O
);
  import omp_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] sel_code(input logic [11:0] oh);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 12; i++) begin
      if (oh[i]) begin
        c = 4'(i);
      end
    end
    return c;
  endfunction

  function automatic logic [11:0] first_hot(input logic [11:0] v);
    logic [11:0] r;
    r = 12'h000;
    for (int i = 11; i >= 0; i--) begin
      if (v[i]) begin
        r = 12'h001 << i;
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rs1_q, rst_n;

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rs1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rst_n <= rs1_q;
    end
  end

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  logic          bm_start, bm_we, bm_done, sys_rst;
  logic [AW-1:0] bm_addr;
  logic [DW-1:0] bm_rdata;

  omp_bus_master #(.AW(AW), .DW(DW)) u_bm (
    .clk_i       (REF_CLK_I),
    .rst_n_i     (rst_n),
    .start_i     (bm_start),
    .we_i        (bm_we),
    .addr_i      (bm_addr),
    .wdata_i     (LED_DATA_O),
    .bus_ack_i   (BUS_ACK_I),
    .bus_rdata_i (BUS_RDATA_I),
    .bus_req_o   (BUS_REQ_O),
    .bus_we_o    (BUS_WE_O),
    .bus_addr_o  (BUS_ADDR_O),
    .bus_wdata_o (BUS_WDATA_O),
    .done_o      (bm_done),
    .rdata_o     (bm_rdata)
  );

  omp_hold_timer #(.HOLD(HOLD)) u_rst (
    .clk_i    (REF_CLK_I),
    .rst_n_i  (rst_n),
    .start_i  (SW_RESET_I),
    .active_o (sys_rst)
  );

  // ----------------------------------------------------------------
  // Panel state
  // ----------------------------------------------------------------
  omp_op_st_t    st_q, st_d;
  logic [AW-1:0] addr_d;
  logic [DW-1:0] data_d;
  logic [11:0]   sel_d;
  logic [3:0]    mask_d;
  logic          ahalt_d, halt_d, armed_d, done_d, seq_d, disp_d;
  logic          call_d, step_d, run_d, load_d, rrd_d, rwr_d;
  logic [31:0]   rdata_d;
  logic          halted, ahalt_hit, live, busy_op, sw_addr_wr, sw_data_wr;
  logic          seq_q, disp_q, rwr_q;

  assign halted     = !CPU_EXEC_I && !CPU_WAIT_I;
  assign ahalt_hit  = LED_ADDR_HALT_O && BUS_MON_VALID_I
                      && (BUS_MON_ADDR_I == LED_ADDR_O);
  assign live       = !sys_rst;
  assign busy_op    = (st_q != OP_IDLE);
  assign sw_addr_wr = REG_WR_I && (REG_ADDR_I == `OMP_OFF_ADDR);
  assign sw_data_wr = REG_WR_I && (REG_ADDR_I == `OMP_OFF_DATA);

  always_comb begin
    st_d     = st_q;
    addr_d   = LED_ADDR_O;
    data_d   = LED_DATA_O;
    sel_d    = LED_SEL_O;
    mask_d   = INT_MASK_O;
    ahalt_d  = LED_ADDR_HALT_O;
    halt_d   = CPU_HALT_O;
    armed_d  = LED_LOAD_O;
    done_d   = LED_DONE_O;
    seq_d    = 1'b0;
    disp_d   = 1'b0;
    call_d   = 1'b0;
    step_d   = 1'b0;
    run_d    = 1'b0;
    load_d   = 1'b0;
    rrd_d    = 1'b0;
    rwr_d    = 1'b0;
    bm_start = 1'b0;
    bm_we    = 1'b0;
    bm_addr  = LED_ADDR_O;
    seq_d    = seq_q;
    disp_d   = disp_q;
    // Software access to address and data
    if (sw_addr_wr) begin
      addr_d = REG_WDATA_I[AW-1:0];
      seq_d  = 1'b0;
    end
    if (sw_data_wr) begin
      data_d = REG_WDATA_I[DW-1:0];
    end
    if (|SW_ADDR_BIT_I) begin
      addr_d = addr_d ^ SW_ADDR_BIT_I;
      seq_d  = 1'b0;
    end
    data_d = data_d ^ SW_DATA_BIT_I;
    if (SW_ADDR_CLR_I) begin
      addr_d = '0;
      seq_d  = 1'b0;
    end
    if (SW_DATA_CLR_I) begin
      data_d = '0;
    end
    if (|SW_SEL_I) begin
      sel_d = first_hot(SW_SEL_I);
    end
    if (live) begin
      call_d = SW_OPER_CALL_I;
      if (SW_INT_MASK_I) begin
        mask_d = INT_MASK_O[0] ? 4'h0 : 4'hF;
      end
      if (SW_ADDR_HALT_I) begin
        ahalt_d = !LED_ADDR_HALT_O;
      end
      if (SW_RUN_I) begin
        run_d  = 1'b1;
        halt_d = 1'b0;
      end
      if (SW_HALT_I && !halted) begin
        halt_d = 1'b1;
      end
      if (ahalt_hit) begin
        halt_d = 1'b1;
      end
      if (SW_STEP_I) begin
        step_d = 1'b1;
        if (!halted) begin
          halt_d = 1'b1;
          disp_d = 1'b1;
        end
      end
      if (SW_LOAD_I && LED_LOAD_O) begin
        load_d  = 1'b1;
        armed_d = 1'b0;
      end
    end
    if (SW_RESET_I) begin
      armed_d = 1'b1;
      halt_d  = 1'b0;
      ahalt_d = 1'b0;
    end
    case (st_q)
      OP_IDLE: begin
        if (!live) begin
          st_d = OP_IDLE;
        end else if (SW_MEM_RD_I) begin
          if (seq_q) begin
            addr_d  = LED_ADDR_O + 1'b1;
            bm_addr = LED_ADDR_O + 1'b1;
          end
          bm_start = 1'b1;
          done_d   = 1'b0;
          st_d     = OP_BUS;
        end else if (SW_MEM_WR_I) begin
          bm_start = 1'b1;
          bm_we    = 1'b1;
          done_d   = 1'b0;
          seq_d    = 1'b0;
          st_d     = OP_BUS;
        end else if (halted && (SW_REG_RD_I || disp_q)) begin
          rrd_d  = 1'b1;
          disp_d = 1'b0;
          done_d = 1'b0;
          st_d   = OP_REG;
        end else if (halted && SW_REG_WR_I) begin
          rwr_d  = 1'b1;
          done_d = 1'b0;
          st_d   = OP_REG;
        end
      end
      OP_BUS: begin
        if (bm_done) begin
          done_d = 1'b1;
          if (!BUS_WE_O) begin
            data_d = bm_rdata;
            seq_d  = 1'b1;
          end
          st_d = OP_IDLE;
        end
      end
      OP_REG: begin
        if (CPU_REG_ACK_I) begin
          done_d = 1'b1;
          if (!CPU_REG_WR_O && !rwr_q) begin
            data_d = CPU_REG_RDATA_I;
          end
          st_d = OP_IDLE;
        end
      end
      default: st_d = OP_IDLE;
    endcase
    // Status and register readback
    rdata_d = 32'h0000_0000;
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        `OMP_OFF_ADDR: rdata_d[AW-1:0] = LED_ADDR_O;
        `OMP_OFF_DATA: rdata_d[DW-1:0] = LED_DATA_O;
        `OMP_OFF_STAT: begin
          rdata_d[`OMP_ST_HALT]   = LED_HALT_O;
          rdata_d[`OMP_ST_RUN]    = LED_RUN_O;
          rdata_d[`OMP_ST_IDLE]   = LED_IDLE_O;
          rdata_d[`OMP_ST_AHALT]  = LED_ADDR_HALT_O;
          rdata_d[`OMP_ST_MASK]   = INT_MASK_O[0];
          rdata_d[`OMP_ST_ARMED]  = LED_LOAD_O;
          rdata_d[`OMP_ST_DONE]   = LED_DONE_O;
          rdata_d[`OMP_ST_XFER]   = busy_op;
          rdata_d[`OMP_ST_BUSY]   = LED_BUSY_O;
          rdata_d[`OMP_ST_SYSRST] = sys_rst;
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      st_q            <= OP_IDLE;
      LED_ADDR_O      <= `OMP_ADDR_RST;
      LED_DATA_O      <= `OMP_DATA_RST;
      LED_SEL_O       <= `OMP_SEL_RST;
      INT_MASK_O      <= 4'h0;
      LED_ADDR_HALT_O <= 1'b0;
      CPU_HALT_O      <= 1'b0;
      LED_LOAD_O      <= 1'b0;
      LED_DONE_O      <= 1'b0;
      seq_q           <= 1'b0;
      disp_q          <= 1'b0;
      rwr_q           <= 1'b0;
      OPER_INT_O      <= 1'b0;
      CPU_STEP_O      <= 1'b0;
      CPU_RUN_O       <= 1'b0;
      AUTOLOAD_O      <= 1'b0;
      CPU_REG_RD_O    <= 1'b0;
      CPU_REG_WR_O    <= 1'b0;
      CPU_REG_SEL_O   <= 4'h0;
      CPU_REG_WDATA_O <= '0;
      REG_RDATA_O     <= 32'h0000_0000;
    end else begin
      st_q            <= st_d;
      LED_ADDR_O      <= addr_d;
      LED_DATA_O      <= data_d;
      LED_SEL_O       <= sel_d;
      INT_MASK_O      <= mask_d;
      LED_ADDR_HALT_O <= ahalt_d;
      CPU_HALT_O      <= halt_d;
      LED_LOAD_O      <= armed_d;
      LED_DONE_O      <= done_d;
      seq_q           <= seq_d;
      disp_q          <= disp_d;
      rwr_q           <= rwr_d || (rwr_q && st_q == OP_REG);
      OPER_INT_O      <= call_d;
      CPU_STEP_O      <= step_d;
      CPU_RUN_O       <= run_d;
      AUTOLOAD_O      <= load_d;
      CPU_REG_RD_O    <= rrd_d;
      CPU_REG_WR_O    <= rwr_d;
      CPU_REG_SEL_O   <= sel_code(sel_d);
      CPU_REG_WDATA_O <= data_d;
      REG_RDATA_O     <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Lights and alarm enables
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      LED_BUSY_O  <= 1'b0;
      LED_RUN_O   <= 1'b0;
      LED_IDLE_O  <= 1'b0;
      LED_HALT_O  <= 1'b0;
      SYS_RESET_O <= 1'b0;
      PF_INT_EN_O <= 1'b0;
      LF_INT_EN_O <= 1'b0;
      PR_MODE_O   <= 2'h0;
    end else begin
      LED_BUSY_O  <= BUS_BUSY_I;
      LED_RUN_O   <= CPU_EXEC_I;
      LED_IDLE_O  <= !CPU_EXEC_I && CPU_WAIT_I;
      LED_HALT_O  <= halted;
      SYS_RESET_O <= sys_rst;
      PF_INT_EN_O <= SW_PF_EN_I;
      LF_INT_EN_O <= SW_LF_EN_I;
      PR_MODE_O   <= SW_PR_MODE_I;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_call_raise: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    SW_OPER_CALL_I && live |=> OPER_INT_O)
    else $error("attention did not interrupt");
  a_mask_set: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    SW_INT_MASK_I && live && INT_MASK_O == 4'h0 |=> INT_MASK_O == 4'hF)
    else $error("inhibit did not mask levels");
  a_ahalt_stop: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    ahalt_hit && live && !SW_RESET_I |=> CPU_HALT_O)
    else $error("address match did not halt");
  a_halt_req: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    SW_HALT_I && live && !halted && !SW_RESET_I |=> CPU_HALT_O)
    else $error("halt switch ignored");
  a_run_start: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    SW_RUN_I && live && !SW_HALT_I && !ahalt_hit && !SW_STEP_I
    |=> CPU_RUN_O && !CPU_HALT_O)
    else $error("run did not start processor");
  a_load_armed: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    AUTOLOAD_O |-> $past(LED_LOAD_O) && !LED_LOAD_O)
    else $error("load without arming");
  a_reset_arms: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    SW_RESET_I |=> LED_LOAD_O ##1 SYS_RESET_O)
    else $error("master reset did not arm");
  a_done_light: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    bm_done && st_q == OP_BUS |=> LED_DONE_O)
    else $error("done light missing");
  a_sel_onehot: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    $onehot(LED_SEL_O))
    else $error("select row not one-hot");
  a_reg_halted: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    $rose(CPU_REG_RD_O) |-> $past(halted))
    else $error("register read while running");
  a_data_clear: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    SW_DATA_CLR_I && st_q == OP_IDLE |=> LED_DATA_O == '0)
    else $error("data clear failed");
  a_one_access: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    BUS_REQ_O |-> !bm_start)
    else $error("second access while busy");

endmodule // omp_panel

/* File: dv/omp_far_model.sv */
// Far side of the panel: one bus target and the processor register port
// Assumes bus requests hold until acknowledged, as the panel contract says
module omp_far_model (
  input  wire logic        REF_CLK_I,
  input  wire logic        BUS_REQ_O,
  input  wire logic [15:0] BUS_ADDR_O,
  input  wire logic        CPU_REG_RD_O,
  input  wire logic        CPU_REG_WR_O,
  input  wire logic [3:0]  CPU_REG_SEL_O,
  output logic             BUS_ACK_I = 0,
  output logic [15:0]      BUS_RDATA_I = 0,
  output logic             CPU_REG_ACK_I = 0,
  output logic [15:0]      CPU_REG_RDATA_I = 0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] wait_q = 0;
  always @(posedge REF_CLK_I) begin
    wait_q <= (BUS_REQ_O && !BUS_ACK_I) ? wait_q + 2'd1 : 2'd0;
    BUS_ACK_I <= BUS_REQ_O && !BUS_ACK_I && wait_q == 2'd2;
    if (BUS_REQ_O && wait_q == 2'd2)
      BUS_RDATA_I <= BUS_ADDR_O ^ 16'hA5A5;
    else
      BUS_RDATA_I <= ~BUS_RDATA_I;
    CPU_REG_ACK_I <= CPU_REG_RD_O | CPU_REG_WR_O;
    if (CPU_REG_RD_O)
      CPU_REG_RDATA_I <= {12'h5A0, CPU_REG_SEL_O};
    else
      CPU_REG_RDATA_I <= ~CPU_REG_RDATA_I;
  end
endmodule // omp_far_model

/* File: dv/operator_maintenance_panel_test.sv */
// Bench for the panel: switch presses, register port, bus far side
// Assumes omp_far_model answers bus and processor requests
module operator_maintenance_panel_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic REF_CLK_I = 0, RST_N_I = 0, CPU_EXEC_I = 0, CPU_WAIT_I = 0;
  logic BUS_BUSY_I = 0, BUS_MON_VALID_I = 0, SW_PF_EN_I = 0;
  logic SW_LF_EN_I = 0, REG_WR_I = 0, REG_RD_I = 0;
  logic [1:0] SW_PR_MODE_I = 0, PR_MODE_O;
  logic [7:0] REG_ADDR_I = 0;
  logic [15:0] BUS_MON_ADDR_I = 0, CPU_REG_RDATA_I, BUS_RDATA_I;
  logic [31:0] REG_WDATA_I = 0, REG_RDATA_O;
  logic [57:0] pv = 0;
  logic SW_OPER_CALL_I, SW_INT_MASK_I, SW_STEP_I, SW_ADDR_HALT_I;
  logic SW_HALT_I, SW_RUN_I;
  logic SW_LOAD_I, SW_RESET_I, SW_REG_RD_I, SW_REG_WR_I, SW_MEM_RD_I;
  logic SW_MEM_WR_I, SW_ADDR_CLR_I, SW_DATA_CLR_I, CPU_REG_ACK_I;
  logic BUS_ACK_I, OPER_INT_O, CPU_HALT_O, CPU_STEP_O, CPU_RUN_O;
  logic CPU_REG_RD_O, CPU_REG_WR_O, SYS_RESET_O, AUTOLOAD_O, PF_INT_EN_O;
  logic LF_INT_EN_O, BUS_REQ_O, BUS_WE_O, LED_ADDR_HALT_O, LED_LOAD_O;
  logic LED_DONE_O, LED_BUSY_O, LED_RUN_O, LED_IDLE_O, LED_HALT_O;
  logic [3:0] INT_MASK_O, CPU_REG_SEL_O;
  logic [11:0] SW_SEL_I, LED_SEL_O;
  logic [15:0] CPU_REG_WDATA_O, BUS_ADDR_O, BUS_WDATA_O, LED_ADDR_O;
  logic [15:0] LED_DATA_O, SW_ADDR_BIT_I, SW_DATA_BIT_I;
  int bad_count = 0, tests_run = 0;
  assign {SW_OPER_CALL_I, SW_INT_MASK_I, SW_STEP_I, SW_ADDR_HALT_I,
    SW_HALT_I, SW_RUN_I,
    SW_LOAD_I, SW_RESET_I, SW_REG_RD_I, SW_REG_WR_I, SW_MEM_RD_I,
    SW_MEM_WR_I, SW_ADDR_CLR_I, SW_DATA_CLR_I, SW_SEL_I, SW_ADDR_BIT_I,
    SW_DATA_BIT_I} = pv;
  omp_panel #(.HOLD(4)) DUT (.*);
  omp_far_model far (.*);
  always #2.5 REF_CLK_I = ~REF_CLK_I;
  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One-cycle switch press, returns just after the taking edge
  task automatic sp(input logic [57:0] v);
    @(posedge REF_CLK_I);
    pv <= v;
    @(posedge REF_CLK_I);
    pv <= '0;
    #1;
  endtask
  task automatic wd;
    for (int i = 0; i < 50; i++) begin
      if (LED_DONE_O === 1'b1) return;
      @(posedge REF_CLK_I);
      #1;
    end
    bad_count++;
    complete_run();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK_I);
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    REG_WR_I <= 1;
    @(posedge REF_CLK_I);
    REG_WR_I <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge REF_CLK_I);
    REG_ADDR_I <= a;
    REG_RD_I <= 1;
    @(posedge REF_CLK_I);
    REG_RD_I <= 0;
    #1 chk("port", REG_RDATA_O, e);
  endtask
  initial begin
    repeat (20) @(posedge REF_CLK_I);
    RST_N_I <= 1;
    repeat (3) @(posedge REF_CLK_I);
    chk("sel", LED_SEL_O, 12'h001);
    sp(58'h12 << 16);
    sp(58'h02 << 16);
    chk("addr", LED_ADDR_O, 16'h0010);
    sp(58'd1 << 47);
    wd();
    chk("data", LED_DATA_O, 16'hA5B5);
    chk("done", LED_DONE_O, 1'b1);
    sp(58'd1 << 47);
    wd();
    chk("next", LED_DATA_O, 16'hA5B4);
    sp(58'd1 << 44);
    chk("dclr", LED_DATA_O, 16'h0);
    sp(58'hC3);
    sp(58'd1 << 46);
    chk("wadr", BUS_ADDR_O, 16'h0011);
    chk("wdat", BUS_WDATA_O, 16'h00C3);
    wd();
    for (int i = 0; i < 12; i++) begin
      sp(58'd1 << (32 + i));
      chk("sel", LED_SEL_O, 12'd1 << i);
      chk("code", CPU_REG_SEL_O, i);
    end
    sp(58'd1 << 49);
    wd();
    chk("rreg", LED_DATA_O, 16'h5A0B);
    sp(58'd1 << 48);
    chk("wreg", CPU_REG_WDATA_O, 16'h5A0B);
    wd();
    wr(8'h00, 32'h1234);
    rd(8'h00, 32'h1234);
    rd(8'h0C, 32'h0);
    sp(58'd1 << 45);
    chk("aclr", LED_ADDR_O, 16'h0);
    chk("hled", LED_HALT_O, 1'b1);
    sp(58'd1 << 53);
    chk("halt", CPU_HALT_O, 1'b0);
    CPU_EXEC_I <= 1;
    BUS_BUSY_I <= 1;
    SW_PF_EN_I <= 1;
    SW_PR_MODE_I <= 2'h2;
    sp(58'd1 << 53);
    chk("halt", CPU_HALT_O, 1'b1);
    chk("rled", LED_RUN_O, 1'b1);
    chk("busy", LED_BUSY_O, 1'b1);
    chk("pf", PF_INT_EN_O, 1'b1);
    chk("pr", PR_MODE_O, 2'h2);
    sp(58'd1 << 52);
    chk("run", CPU_RUN_O, 1'b1);
    sp(58'd1 << 54);
    chk("ahled", LED_ADDR_HALT_O, 1'b1);
    BUS_MON_VALID_I <= 1;
    sp(58'h0);
    BUS_MON_VALID_I <= 0;
    chk("ahalt", CPU_HALT_O, 1'b1);
    sp(58'd1 << 54);
    chk("ahoff", LED_ADDR_HALT_O, 1'b0);
    sp(58'd1 << 55);
    chk("step", CPU_STEP_O, 1'b1);
    sp(58'd1 << 56);
    chk("mask", INT_MASK_O, 4'hF);
    sp(58'd1 << 56);
    chk("unmask", INT_MASK_O, 4'h0);
    sp(58'd1 << 57);
    chk("call", OPER_INT_O, 1'b1);
    sp(58'd1 << 51);
    chk("load", AUTOLOAD_O, 1'b0);
    sp(58'd1 << 50);
    chk("arm", LED_LOAD_O, 1'b1);
    repeat (2) @(posedge REF_CLK_I);
    chk("sysr", SYS_RESET_O, 1'b1);
    repeat (10) @(posedge REF_CLK_I);
    sp(58'd1 << 51);
    chk("load", AUTOLOAD_O, 1'b1);
    CPU_EXEC_I <= 0;
    CPU_WAIT_I <= 1;
    SW_LF_EN_I <= 1;
    sp(58'h0);
    chk("iled", LED_IDLE_O, 1'b1);
    chk("rled0", LED_RUN_O, 1'b0);
    chk("lf", LF_INT_EN_O, 1'b1);
    complete_run();
  end
endmodule // operator_maintenance_panel_test
